// ==== sim/psd_chk.sv ====
`default_nettype none
module psd_chk (
   input wire logic       SYS_CLK_I,
   input wire logic       RST_N_I,
   input wire logic       SPI_ACTIVE_I,
   input wire logic [3:0] SPI_DIR_I,
   input wire logic       TWO_WIRE_ACTIVE_I,
   input wire logic [3:0] PULSE_ACTIVE_I,
   input wire logic       TWO_WIRE_DIR_SDA_I,
   input wire logic       TWO_WIRE_DIR_SCL_I,
   input wire logic [3:0] PIN_OE_O,
   input wire logic [3:0] PIN_OPEN_DRAIN_O,
   input wire logic [3:0] PIN_OVERRIDDEN_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   wire logic ns = !SPI_ACTIVE_I;
   wire logic nt = ns && !TWO_WIRE_ACTIVE_I;
   property p_spi; SPI_ACTIVE_I |=> PIN_OE_O == $past(SPI_DIR_I) && !PIN_OPEN_DRAIN_O; endproperty
   a_spi: assert property (p_spi) else $error("spi dir");
   property p_od7; ns && TWO_WIRE_ACTIVE_I |=> PIN_OPEN_DRAIN_O[3]; endproperty
   a_od7: assert property (p_od7) else $error("od7");
   property p_od4; ns && TWO_WIRE_ACTIVE_I |=> PIN_OPEN_DRAIN_O[0]; endproperty
   a_od4: assert property (p_od4) else $error("od4");
   property p_ch3; nt && PULSE_ACTIVE_I[3] |=> PIN_OE_O[3]; endproperty
   a_ch3: assert property (p_ch3) else $error("ch3");
   property p_ch2; ns && PULSE_ACTIVE_I[2] |=> PIN_OE_O[2]; endproperty
   a_ch2: assert property (p_ch2) else $error("ch2");
   property p_ch1; ns && PULSE_ACTIVE_I[1] |=> PIN_OE_O[1]; endproperty
   a_ch1: assert property (p_ch1) else $error("ch1");
   property p_ch0; nt && PULSE_ACTIVE_I[0] |=> PIN_OE_O[0]; endproperty
   a_ch0: assert property (p_ch0) else $error("ch0");
   property p_spi_ovr; SPI_ACTIVE_I |=> PIN_OVERRIDDEN_O == 4'hf; endproperty
   a_spi_ovr: assert property (p_spi_ovr) else $error("spi override flags");
   property p_tw7;
      ns && TWO_WIRE_ACTIVE_I |=> PIN_OE_O[3] == $past(TWO_WIRE_DIR_SDA_I);
   endproperty
   a_tw7: assert property (p_tw7) else $error("two-wire dir pin 7");
   property p_tw4;
      ns && TWO_WIRE_ACTIVE_I |=> PIN_OE_O[0] == $past(TWO_WIRE_DIR_SCL_I);
   endproperty
   a_tw4: assert property (p_tw4) else $error("two-wire dir pin 4");
   property p_rst; $rose(RST_N_I) |-> PIN_OE_O == 4'h0; endproperty
   a_rst: assert property (p_rst) else $error("oe after reset");
endmodule // psd_chk
bind psd_port_dir psd_chk u_chk (.*);
`default_nettype wire

// ==== sim/psd_periph.sv ====
`default_nettype none
module psd_periph (
   input  wire logic        clk_i,
   input  wire logic [11:0] cmd_i,
   output var  logic [11:0] drv_o = 12'h000
);
   timeunit 1ns;
   timeprecision 1ns;
   // peripheral levels move on the rising edge itself, with no delay after it
   always @(posedge clk_i) drv_o <= cmd_i;
endmodule // psd_periph
`default_nettype wire

// ==== sim/psd_port_dir_tb_top.sv ====
`default_nettype none
module psd_port_dir_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0;
   logic [3:0] addr = 4'h0, oe, od, ovrd;
   logic [7:0] wd = 8'h00, rdat;
   logic [11:0] cmd = 12'h000, drv;
   int err_count = 0, n_checks = 0, cyc = 0;
   psd_periph m (.clk_i(clk), .cmd_i(cmd), .drv_o(drv));
   psd_port_dir uut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wd),
      .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .SPI_ACTIVE_I(drv[11]), .SPI_DIR_I(drv[10:7]),
      .TWO_WIRE_ACTIVE_I(drv[6]), .TWO_WIRE_DIR_SDA_I(drv[5]), .TWO_WIRE_DIR_SCL_I(drv[4]),
      .PULSE_ACTIVE_I(drv[3:0]), .PIN_OE_O(oe), .PIN_OPEN_DRAIN_O(od), .PIN_OVERRIDDEN_O(ovrd));
   initial forever #25 clk = ~clk;
   task test_done;
      if (err_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         test_done;
      end
   end
   task chk_rd(input logic [7:0] g, e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t read got %h want %h", $time, g, e);
      end
   endtask
   task chk_pins(input logic [11:0] g, e);
      n_checks++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %0t pins got %h want %h", $time, g, e);
      end
   endtask
   task wreg(input logic [7:0] d);
      addr <= 4'h0; wd <= d; wr <= 1'b1;
      @(posedge clk) wr <= 1'b0;
   endtask
   task rreg(input logic [3:0] a, input logic [7:0] e);
      addr <= a; rd <= 1'b1;
      @(posedge clk) rd <= 1'b0;
      #1 chk_rd(rdat, e);
      @(posedge clk);
   endtask
   // pins settle two edges after the command: model stage plus output register
   // compared as {direction, open drain, overridden}
   task pins(input logic [11:0] e);
      repeat (3) @(posedge clk);
      #1 chk_pins({oe, od, ovrd}, e);
      @(posedge clk);
   endtask
   task ovr(input logic [11:0] c, input logic [11:0] e);
      cmd <= c;
      pins(e);
   endtask
   task t_reset;
      pins(12'h000);
      rreg(4'h0, 8'h00);
   endtask
   task t_dir;
      wreg(8'hF0);
      pins(12'hF00);
      wreg(8'h5A);
      rreg(4'h0, 8'h5A);
      rreg(4'hF, 8'h00);
      pins(12'h500);
      wreg(8'hA0);
   endtask
   task t_ovr;
      ovr(12'hB4F, 12'h60F);
      ovr(12'h87F, 12'h00F);
      ovr(12'h05F, 12'h79F);
      rreg(4'h1, 8'h7F);
      ovr(12'h009, 12'hB09);
      ovr(12'h006, 12'hE06);
      ovr(12'h000, 12'hA00);
   endtask
   // a second reset must clear a direction byte that software had set
   task t_rerun;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rreg(4'h0, 8'h00);
      pins(12'h000);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_dir;
      t_ovr;
      t_rerun;
      test_done;
   end
endmodule // psd_port_dir_tb_top
`default_nettype wire

// ==== verilog/psd_defines.vh ====
`ifndef PSD_DEFINES_VH
`define PSD_DEFINES_VH
// ****************************************************
// register map
// ****************************************************
`define PSD_ADDR_W          4
`define PSD_DIR_OFFSET      4'h0
`define PSD_STATUS_OFFSET   4'h1
`define PSD_DIR_RESET       8'h00
`define PSD_UNMAPPED_READ   8'h00
// ****************************************************
// pin positions
// ****************************************************
`define PSD_PIN_TWO_WIRE_A  3
`define PSD_PIN_CH0         0
`endif

// ==== verilog/psd_dir_reg.v ====
`include "psd_defines.vh"
`default_nettype none
// ****************************************************
// direction storage: one byte, read data registered
// ****************************************************
module psd_dir_reg (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire       wr_i,
   input  wire       rd_i,
   input  wire [7:0] wdata_i,
   output reg  [7:0] value_o,
   output reg  [7:0] rdata_o
);
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         value_o <= `PSD_DIR_RESET;
         rdata_o <= 8'h00;
      end else begin
         // no mode gating and no write-once lock; overrides never touch the store
         if (wr_i) begin
            value_o <= wdata_i;
         end
         if (rd_i) begin
            rdata_o <= value_o;
         end
      end
   end
endmodule // psd_dir_reg
`default_nettype wire

// ==== verilog/psd_port_dir.v ====
`include "psd_defines.vh"
`default_nettype none
module psd_port_dir (
   input  wire                   SYS_CLK_I,
   input  wire                   RST_N_I,
   input  wire [`PSD_ADDR_W-1:0] ADDR_I,
   input  wire [7:0]             WDATA_I,
   input  wire                   WR_I,
   input  wire                   RD_I,
   output reg  [7:0]             RDATA_O,
   input  wire                   SPI_ACTIVE_I,
   input  wire [3:0]             SPI_DIR_I,
   input  wire                   TWO_WIRE_ACTIVE_I,
   input  wire                   TWO_WIRE_DIR_SCL_I,
   input  wire                   TWO_WIRE_DIR_SDA_I,
   input  wire [3:0]             PULSE_ACTIVE_I,
   output reg  [3:0]             PIN_OE_O,
   output reg  [3:0]             PIN_OPEN_DRAIN_O,
   output reg  [3:0]             PIN_OVERRIDDEN_O
);
   // ****************************************************
   // register access
   // ****************************************************
   // one address compare shared by every register select
   function psd_hit;
      input [`PSD_ADDR_W-1:0] addr;
      input [`PSD_ADDR_W-1:0] offset;
      begin
         psd_hit = (addr == offset);
      end
   endfunction

   wire       dir_wr  = WR_I && psd_hit(ADDR_I, `PSD_DIR_OFFSET);
   wire       dir_rd  = RD_I && psd_hit(ADDR_I, `PSD_DIR_OFFSET);
   wire       stat_rd = RD_I && psd_hit(ADDR_I, `PSD_STATUS_OFFSET);
   wire [7:0] dir_value;

   // read data are taken from the stored value here so that RDATA_O is itself a flip-flop
   psd_dir_reg u_dir (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RST_N_I),
      .wr_i    (dir_wr),
      .rd_i    (dir_rd),
      .wdata_i (WDATA_I),
      .value_o (dir_value),
      .rdata_o ()
   );

   // ****************************************************
   // override priority per pin
   // ****************************************************
   // peripheral enables arrive from logic on this clock, so no synchroniser
   // result is {output enable, open drain, overridden}, highest source first
   function [2:0] psd_pin_dir;
      input dir_bit;
      input spi_act;
      input spi_dir;
      input tw_act;
      input tw_dir;
      input pulse_act;
      begin
         if (spi_act) begin
            psd_pin_dir = {spi_dir, 1'b0, 1'b1};
         end else if (tw_act) begin
            psd_pin_dir = {tw_dir, 1'b1, 1'b1};
         end else if (pulse_act) begin
            psd_pin_dir = 3'h5;
         end else begin
            psd_pin_dir = {dir_bit, 1'b0, 1'b0};
         end
      end
   endfunction

   // pins 6 and 5 have no two-wire source, so that stage is held off for them
   wire [2:0] pin7_sel = psd_pin_dir(dir_value[7], SPI_ACTIVE_I, SPI_DIR_I[3],
                                     TWO_WIRE_ACTIVE_I, TWO_WIRE_DIR_SDA_I,
                                     PULSE_ACTIVE_I[3]);
   wire [2:0] pin6_sel = psd_pin_dir(dir_value[6], SPI_ACTIVE_I, SPI_DIR_I[2],
                                     1'b0, 1'b0,
                                     PULSE_ACTIVE_I[2]);
   wire [2:0] pin5_sel = psd_pin_dir(dir_value[5], SPI_ACTIVE_I, SPI_DIR_I[1],
                                     1'b0, 1'b0,
                                     PULSE_ACTIVE_I[1]);
   wire [2:0] pin4_sel = psd_pin_dir(dir_value[4], SPI_ACTIVE_I, SPI_DIR_I[0],
                                     TWO_WIRE_ACTIVE_I, TWO_WIRE_DIR_SCL_I,
                                     PULSE_ACTIVE_I[0]);

   wire [3:0] next_oe  = {pin7_sel[2], pin6_sel[2], pin5_sel[2], pin4_sel[2]};
   wire [3:0] next_od  = {pin7_sel[1], pin6_sel[1], pin5_sel[1], pin4_sel[1]};
   wire [3:0] next_ovr = {pin7_sel[0], pin6_sel[0], pin5_sel[0], pin4_sel[0]};

   // ****************************************************
   // output registers
   // ****************************************************
   // status view: live pin directions in the upper nibble, overrides in the lower
   always @(posedge SYS_CLK_I) begin
      if (!RST_N_I) begin
         PIN_OE_O         <= 4'h0;
         PIN_OPEN_DRAIN_O <= 4'h0;
         PIN_OVERRIDDEN_O <= 4'h0;
         RDATA_O          <= 8'h00;
      end else begin
         PIN_OE_O         <= next_oe;
         PIN_OPEN_DRAIN_O <= next_od;
         PIN_OVERRIDDEN_O <= next_ovr;
         // read data stand only in the cycle after the strobe
         if (dir_rd) begin
            RDATA_O <= dir_value;
         end else if (stat_rd) begin
            RDATA_O <= {next_oe, next_ovr};
         end else begin
            RDATA_O <= `PSD_UNMAPPED_READ;
         end
      end
   end
endmodule // psd_port_dir
`default_nettype wire
